// >>> hw/dual_serial_printer_register_decode.sv
// Register decode for two serial channels and a bidirectional printer port.
// Assumes bus strobes are synchronous to i_clk and serial engines sit outside.

// Function
// - A serial channel's registers answer only while its select is low.
// - The printer registers answer only while the printer select is low, using the 8-bit printer data bus.
// - Address 0 of a selected channel reads receive holding and writes transmit holding.
// - With line control bit 7 set, addresses 0 and 1 reach the divisor low and high bytes.
// - Printer access ignores address bit 2; 00 is data, 01 status or direction select, 10 command or control.
// - Printer data direction follows the bidirectional enable pin with control bit 5 or direction select.
// - One baud generator per channel times both transmit and receive.
// - The generator divides by any divisor from 1 to 65535.
// - The bit period is sixteen divided ticks.
// - The divisor is the high byte over the low byte.
// - The generator runs only from the reference clock, up to 24 MHz.
// - Each transmit line rests at 1 in reset, idle and while disabled.
module dual_serial_printer_register_decode #(
	parameter int unsigned CHANNELS = 2
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Host register bus.
	input wire logic i_serial_a_select_n,
	input wire logic i_serial_b_select_n,
	input wire logic i_printer_select_n,
	input wire logic [2:0] i_addr,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data,
	output logic o_rd_data_oe,
	// Serial engine side.
	input wire logic [7:0] i_receive_holding [CHANNELS],
	input wire logic [7:0] i_interrupt_status [CHANNELS],
	input wire logic [7:0] i_line_status [CHANNELS],
	input wire logic [7:0] i_modem_status [CHANNELS],
	input wire logic [CHANNELS-1:0] i_tx_active,
	input wire logic [CHANNELS-1:0] i_tx_bit,
	output logic [7:0] o_transmit_holding [CHANNELS],
	output logic [CHANNELS-1:0] o_transmit_load,
	output logic [CHANNELS-1:0] o_receive_read,
	output logic [7:0] o_interrupt_enable [CHANNELS],
	output logic [7:0] o_line_control [CHANNELS],
	output logic [7:0] o_modem_control [CHANNELS],
	output logic [CHANNELS-1:0] o_tick16,
	output logic [CHANNELS-1:0] o_bit_tick,
	output logic [CHANNELS-1:0] o_tx_serial,
	// Printer port.
	input wire logic i_bidirectional_enable_pin,
	input wire logic [7:0] i_printer_data_bus,
	input wire logic [7:0] i_printer_status,
	input wire logic [7:0] i_printer_command_readback,
	output logic [7:0] o_printer_data_bus,
	output logic o_printer_data_oe,
	output logic [7:0] o_printer_control
);

	logic [7:0] scratch_byte [CHANNELS];
	logic [7:0] divisor_low_byte [CHANNELS];
	logic [7:0] divisor_high_byte [CHANNELS];
	logic [7:0] printer_direction_select;
	logic [CHANNELS-1:0] chan_sel;
	logic serial_sel;
	logic chan_idx;
	logic printer_sel;
	logic wr_act;
	logic wr_act_q;
	logic rd_act;
	logic rd_act_q;
	logic wr_take;
	logic rd_take;
	logic divisor_access;
	logic printer_input_dir;
	logic [7:0] next_rd_data;

	// Channel A wins if the host selects both channels at once.
	always_comb begin
		chan_sel = '0;
		if (!i_serial_a_select_n) begin
			chan_sel[0] = 1'b1;
		end else if (!i_serial_b_select_n) begin
			chan_sel[1] = 1'b1;
		end
	end

	assign serial_sel = |chan_sel;
	assign chan_idx = chan_sel[1];
	assign printer_sel = !serial_sel && !i_printer_select_n;
	assign divisor_access = o_line_control[chan_idx][serial_printer_pkg::LINE_CONTROL_DIVISOR_BIT];
	assign wr_act = !i_wr_n && (serial_sel || printer_sel);
	assign rd_act = !i_rd_n && (serial_sel || printer_sel);
	// One access per strobe: only the first cycle of a low strobe acts.
	assign wr_take = wr_act && !wr_act_q;
	assign rd_take = rd_act && !rd_act_q;

	// The bidirectional pin gates both software direction controls.
	assign printer_input_dir = i_bidirectional_enable_pin
		&& (o_printer_control[serial_printer_pkg::PCTRL_INPUT_DIR_BIT]
		|| (printer_direction_select == serial_printer_pkg::DIR_SELECT_INPUT));

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
		end
	end

	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		logic hit_wr;
		logic div_wr;
		logic [15:0] divisor;

		assign hit_wr = wr_take && chan_sel[c];
		assign div_wr = hit_wr && o_line_control[c][serial_printer_pkg::LINE_CONTROL_DIVISOR_BIT]
			&& ((i_addr == serial_printer_pkg::ADDR_DIVISOR_LOW) || (i_addr == serial_printer_pkg::ADDR_DIVISOR_HIGH));
		assign divisor = {divisor_high_byte[c], divisor_low_byte[c]};

		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				o_transmit_holding[c] <= serial_printer_pkg::RESET_BYTE;
				o_interrupt_enable[c] <= serial_printer_pkg::RESET_BYTE;
				o_line_control[c] <= serial_printer_pkg::RESET_BYTE;
				o_modem_control[c] <= serial_printer_pkg::RESET_BYTE;
				scratch_byte[c] <= serial_printer_pkg::RESET_BYTE;
				divisor_low_byte[c] <= serial_printer_pkg::RESET_DIVISOR[7:0];
				divisor_high_byte[c] <= serial_printer_pkg::RESET_DIVISOR[15:8];
				o_transmit_load[c] <= 1'b0;
			end else begin
				o_transmit_load[c] <= 1'b0;
				if (div_wr) begin
					if (i_addr == serial_printer_pkg::ADDR_DIVISOR_LOW) begin
						divisor_low_byte[c] <= i_wr_data;
					end else begin
						divisor_high_byte[c] <= i_wr_data;
					end
				end else if (hit_wr) begin
					case (i_addr)
						serial_printer_pkg::ADDR_HOLDING: begin
							o_transmit_holding[c] <= i_wr_data;
							o_transmit_load[c] <= 1'b1;
						end
						serial_printer_pkg::ADDR_INT: o_interrupt_enable[c] <= i_wr_data;
						serial_printer_pkg::ADDR_LINE_CONTROL: o_line_control[c] <= i_wr_data;
						serial_printer_pkg::ADDR_MODEM_CONTROL: o_modem_control[c] <= i_wr_data;
						serial_printer_pkg::ADDR_SCRATCH: scratch_byte[c] <= i_wr_data;
						default: begin
						end
					endcase
				end
			end
		end

		// Popping the receive holding register is a side effect of reading it.
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				o_receive_read[c] <= 1'b0;
			end else begin
				o_receive_read[c] <= rd_take && chan_sel[c] && (i_addr == serial_printer_pkg::ADDR_HOLDING)
					&& !o_line_control[c][serial_printer_pkg::LINE_CONTROL_DIVISOR_BIT];
			end
		end

		// Line is forced to mark unless the engine is actively shifting.
		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				o_tx_serial[c] <= 1'b1;
			end else begin
				o_tx_serial[c] <= i_tx_active[c] ? i_tx_bit[c] : 1'b1;
			end
		end

		// The same ticks time transmitter and receiver; i_clk is the only reference.
		baud_divider #(
			.DIV_W(16)
		) u_baud (
			.i_clk(i_clk),
			.i_arst_n(i_arst_n),
			.i_divisor(divisor),
			.i_reload(div_wr),
			.o_tick16(o_tick16[c]),
			.o_bit_tick(o_bit_tick[c])
		);
	end

	// Printer port registers.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_printer_data_bus <= serial_printer_pkg::RESET_BYTE;
			o_printer_control <= serial_printer_pkg::RESET_BYTE;
			printer_direction_select <= serial_printer_pkg::RESET_BYTE;
		end else if (wr_take && printer_sel) begin
			case (i_addr[1:0])
				serial_printer_pkg::ADDR_PRINTER_DATA: o_printer_data_bus <= i_wr_data;
				serial_printer_pkg::ADDR_PRINTER_STATUS: begin
					// Only the two defined patterns change direction; others are ignored.
					if ((i_wr_data == serial_printer_pkg::DIR_SELECT_INPUT)
						|| (i_wr_data == serial_printer_pkg::DIR_SELECT_OUTPUT)) begin
						printer_direction_select <= i_wr_data;
					end
				end
				serial_printer_pkg::ADDR_PRINTER_CONTROL: o_printer_control <= i_wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_printer_data_oe <= 1'b1;
		end else begin
			o_printer_data_oe <= !printer_input_dir;
		end
	end

	// Read data mux.
	always_comb begin
		next_rd_data = 8'h00;
		if (serial_sel) begin
			if (divisor_access && (i_addr == serial_printer_pkg::ADDR_DIVISOR_LOW)) begin
				next_rd_data = divisor_low_byte[chan_idx];
			end else if (divisor_access && (i_addr == serial_printer_pkg::ADDR_DIVISOR_HIGH)) begin
				next_rd_data = divisor_high_byte[chan_idx];
			end else begin
				case (i_addr)
					serial_printer_pkg::ADDR_HOLDING: next_rd_data = i_receive_holding[chan_idx];
					serial_printer_pkg::ADDR_INT: next_rd_data = i_interrupt_status[chan_idx];
					serial_printer_pkg::ADDR_LINE_CONTROL: next_rd_data = o_line_control[chan_idx];
					serial_printer_pkg::ADDR_MODEM_CONTROL: next_rd_data = o_modem_control[chan_idx];
					serial_printer_pkg::ADDR_LINE_STATUS: next_rd_data = i_line_status[chan_idx];
					serial_printer_pkg::ADDR_MODEM_STATUS: next_rd_data = i_modem_status[chan_idx];
					serial_printer_pkg::ADDR_SCRATCH: next_rd_data = scratch_byte[chan_idx];
					default: next_rd_data = 8'h00;
				endcase
			end
		end else if (printer_sel) begin
			case (i_addr[1:0])
				serial_printer_pkg::ADDR_PRINTER_DATA:
					next_rd_data = printer_input_dir ? i_printer_data_bus : o_printer_data_bus;
				serial_printer_pkg::ADDR_PRINTER_STATUS: next_rd_data = i_printer_status;
				serial_printer_pkg::ADDR_PRINTER_CONTROL: next_rd_data = i_printer_command_readback;
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rd_data <= 8'h00;
			o_rd_data_oe <= 1'b0;
		end else begin
			o_rd_data <= rd_act ? next_rd_data : 8'h00;
			o_rd_data_oe <= rd_act;
		end
	end

endmodule

// >>> hw/serial_printer_pkg.sv
// Shared constants for the dual serial channel and printer port register decode.
// Assumes a single 20 MHz clock that also serves as the baud reference clock.
package serial_printer_pkg;

	// Clock figures.
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned REF_CLK_MAX_HZ = 24000000;
	localparam int unsigned PRESCALE = 16;
	localparam int unsigned PHASE_W = $clog2(PRESCALE);

	// Serial general register set offsets.
	localparam logic [2:0] ADDR_HOLDING = 3'h0;
	localparam logic [2:0] ADDR_INT = 3'h1;
	localparam logic [2:0] ADDR_LINE_CONTROL = 3'h3;
	localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
	localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
	localparam logic [2:0] ADDR_SCRATCH = 3'h7;

	// Divisor latch offsets.
	localparam logic [2:0] ADDR_DIVISOR_LOW = 3'h0;
	localparam logic [2:0] ADDR_DIVISOR_HIGH = 3'h1;

	// Printer port offsets, two low address bits only.
	localparam logic [1:0] ADDR_PRINTER_DATA = 2'h0;
	localparam logic [1:0] ADDR_PRINTER_STATUS = 2'h1;
	localparam logic [1:0] ADDR_PRINTER_CONTROL = 2'h2;

	// Field positions.
	localparam int unsigned LINE_CONTROL_DIVISOR_BIT = 7;
	localparam int unsigned PCTRL_INPUT_DIR_BIT = 5;

	// Direction select patterns.
	localparam logic [7:0] DIR_SELECT_INPUT = 8'haa;
	localparam logic [7:0] DIR_SELECT_OUTPUT = 8'h55;

	// Values after reset.
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [15:0] RESET_DIVISOR = 16'h0000;

endpackage

// >>> hw/baud_divider.sv
// Programmable baud divider for one serial channel.
// Assumes the divisor and reload come from registers in the same clock domain.
module baud_divider #(
	parameter int unsigned DIV_W = 16
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Divisor control.
	input wire logic [DIV_W-1:0] i_divisor,
	input wire logic i_reload,
	// Timing outputs.
	output logic o_tick16,
	output logic o_bit_tick
);

	logic [DIV_W-1:0] count;
	logic [serial_printer_pkg::PHASE_W-1:0] phase;

	// A divisor of zero stops the generator rather than wrapping to a huge count.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			count <= '0;
			o_tick16 <= 1'b0;
		end else if (i_reload) begin
			count <= i_divisor;
			o_tick16 <= 1'b0;
		end else begin
			count <= (count <= DIV_W'(1)) ? i_divisor : count - DIV_W'(1);
			o_tick16 <= (i_divisor != '0) && (count <= DIV_W'(1));
		end
	end

	// Sixteen divided ticks make one bit period.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			phase <= '0;
			o_bit_tick <= 1'b0;
		end else if (i_reload) begin
			phase <= '0;
			o_bit_tick <= 1'b0;
		end else begin
			if (o_tick16) begin
				phase <= phase + 1'b1;
			end
			o_bit_tick <= o_tick16 && (phase == '1);
		end
	end

endmodule

// >>> tb/dsprd_chk.sv
// Port checker for the register decode: channel A, printer port and read path.
// Assumes one clock domain; bound to the decode module below.
module dsprd_chk #(
	parameter int unsigned CHANNELS = 2
) (
	// Watched ports.
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_serial_a_select_n,
	input wire logic i_serial_b_select_n,
	input wire logic i_printer_select_n,
	input wire logic [2:0] i_addr,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [7:0] i_wr_data,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_data_oe,
	input wire logic [CHANNELS-1:0] i_tx_active,
	input wire logic [CHANNELS-1:0] i_tx_bit,
	input wire logic [7:0] o_transmit_holding [CHANNELS],
	input wire logic [CHANNELS-1:0] o_transmit_load,
	input wire logic [CHANNELS-1:0] o_receive_read,
	input wire logic [7:0] o_line_control [CHANNELS],
	input wire logic [CHANNELS-1:0] o_tick16,
	input wire logic [CHANNELS-1:0] o_bit_tick,
	input wire logic [CHANNELS-1:0] o_tx_serial,
	input wire logic i_bidirectional_enable_pin,
	input wire logic o_printer_data_oe,
	input wire logic [7:0] o_printer_data_bus
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	sequence s_a_hold;
		!i_serial_a_select_n && i_addr == 3'h0 && !o_line_control[0][7];
	endsequence
	sequence s_prn_wr;
		!i_wr_n && $past(i_wr_n) && i_serial_a_select_n && i_serial_b_select_n && !i_printer_select_n
			&& i_addr[1:0] == 2'h0;
	endsequence
	property p_tx_rest;
		1'b1 |=> o_tx_serial[0] == ($past(i_tx_active[0]) ? $past(i_tx_bit[0]) : 1'b1);
	endproperty
	property p_rd_idle;
		i_rd_n |=> o_rd_data == 8'h00 && !o_rd_data_oe;
	endproperty
	property p_tx_load;
		s_a_hold and (!i_wr_n && $past(i_wr_n)) |=> o_transmit_load[0] && o_transmit_holding[0] == $past(i_wr_data);
	endproperty
	property p_rx_read;
		s_a_hold and (!i_rd_n && $past(i_rd_n)) |=> o_receive_read[0];
	endproperty
	property p_bit_after;
		o_bit_tick[0] |-> $past(o_tick16[0]);
	endproperty
	property p_bit_gap;
		o_bit_tick[0] |=> !o_bit_tick[0] [*8];
	endproperty
	property p_dir_force;
		!i_bidirectional_enable_pin |=> o_printer_data_oe;
	endproperty
	property p_prn_wr;
		s_prn_wr |=> o_printer_data_bus == $past(i_wr_data);
	endproperty
	a_tx_rest: assert property (p_tx_rest) else $error("tx line not resting high");
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	a_tx_load: assert property (p_tx_load) else $error("holding write lost");
	a_rx_read: assert property (p_rx_read) else $error("holding read not flagged");
	a_bit_after: assert property (p_bit_after) else $error("bit tick without tick");
	a_bit_gap: assert property (p_bit_gap) else $error("bit ticks too close");
	a_dir_force: assert property (p_dir_force) else $error("port not driving");
	a_prn_wr: assert property (p_prn_wr) else $error("port data write lost");
endmodule

bind dual_serial_printer_register_decode dsprd_chk #(.CHANNELS(CHANNELS)) chk_u (
	.i_clk(i_clk), .i_arst_n(i_arst_n), .i_serial_a_select_n(i_serial_a_select_n),
	.i_serial_b_select_n(i_serial_b_select_n), .i_printer_select_n(i_printer_select_n), .i_addr(i_addr),
	.i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_rd_data_oe(o_rd_data_oe),
	.i_tx_active(i_tx_active), .i_tx_bit(i_tx_bit), .o_transmit_holding(o_transmit_holding),
	.o_transmit_load(o_transmit_load), .o_receive_read(o_receive_read), .o_line_control(o_line_control),
	.o_tick16(o_tick16), .o_bit_tick(o_bit_tick), .o_tx_serial(o_tx_serial),
	.i_bidirectional_enable_pin(i_bidirectional_enable_pin), .o_printer_data_oe(o_printer_data_oe),
	.o_printer_data_bus(o_printer_data_bus)
);

// >>> tb/host_model.sv
// Host CPU model for the register bus of the decode block.
// Assumes one clock; the bus changes just after rising edges.
module host_model (
	// Clock.
	input wire logic i_clk,
	// Bus towards the block.
	output logic [2:0] o_sel_n,
	output logic [2:0] o_addr,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic [7:0] o_wr_data,
	input wire logic [7:0] i_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_sel_n = 3'h7;
		o_addr = 3'h0;
		o_rd_n = 1'b1;
		o_wr_n = 1'b1;
		o_wr_data = 8'h00;
	end
	// Strobe held two edges; the idle bus shows inverted leftovers, not the old values.
	task automatic acc(input logic wr, input logic [2:0] sel_n, input logic [2:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_sel_n <= sel_n;
		o_addr <= a;
		o_wr_data <= d;
		o_rd_n <= wr;
		o_wr_n <= !wr;
		repeat (2) @(posedge i_clk);
		q = i_rd_data;
		o_sel_n <= 3'h7;
		o_rd_n <= 1'b1;
		o_wr_n <= 1'b1;
		o_addr <= ~a;
		o_wr_data <= ~d;
	endtask
endmodule

// >>> tb/tb_dual_serial_printer_register_decode.sv
// Self-checking bench for the register decode with random engine and pin values.
// Assumes the host model drives the bus and the checker is bound to the design.
module tb_dual_serial_printer_register_decode;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [2:0] sel_n, addr;
	logic rd_n, wr_n, poe, pin = 1'b1;
	logic [7:0] wd, rdd, pout, pctl, q, pins = 8'h00, pstat = 8'h00, pcmd = 8'h00;
	logic [7:0] rxh [2] = '{8'h00, 8'h00}, ist [2] = '{8'h00, 8'h00}, txh [2];
	logic [1:0] txa = 2'h0, txb = 2'h0, t16, btk, txs;
	logic [7:0] ienb [2], mctl [2], lst [2] = '{8'h00, 8'h00};
	logic roe;
	logic [31:0] seed = 32'hf957;
	int n_fail = 0, comparisons = 0;
	always #25 i_clk = ~i_clk;
	host_model host_u (.i_clk(i_clk), .o_sel_n(sel_n), .o_addr(addr), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_wr_data(wd), .i_rd_data(rdd));
	dual_serial_printer_register_decode dut_u (
		.i_clk(i_clk), .i_arst_n(i_arst_n), .i_serial_a_select_n(sel_n[0]), .i_serial_b_select_n(sel_n[1]),
		.i_printer_select_n(sel_n[2]), .i_addr(addr), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_wr_data(wd),
		.o_rd_data(rdd), .o_rd_data_oe(roe), .i_receive_holding(rxh), .i_interrupt_status(ist),
		.i_line_status(lst), .i_modem_status(ist), .i_tx_active(txa), .i_tx_bit(txb),
		.o_transmit_holding(txh), .o_transmit_load(), .o_receive_read(), .o_interrupt_enable(ienb),
		.o_line_control(), .o_modem_control(mctl), .o_tick16(t16), .o_bit_tick(btk), .o_tx_serial(txs),
		.i_bidirectional_enable_pin(pin), .i_printer_data_bus(pins), .i_printer_status(pstat),
		.i_printer_command_readback(pcmd), .o_printer_data_bus(pout), .o_printer_data_oe(poe),
		.o_printer_control(pctl)
	);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic oe_exp(input logic p, input logic c5, input logic aa);
		return !(p && (c5 || aa));
	endfunction
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic stir();
		@(posedge i_clk);
		seed = lfsr(seed);
		rxh <= '{seed[7:0], seed[15:8]};
		ist <= '{seed[23:16], seed[31:24]};
		lst <= '{seed[31:24], seed[7:0]};
		pins <= seed[15:8] ^ 8'h3c;
		pstat <= seed[23:16];
		pcmd <= seed[31:24] ^ 8'ha5;
		txa <= seed[1:0];
		txb <= seed[5:4];
	endtask
	// Cycles between the first two pulses seen; zero if they never come.
	task automatic gap(input int c, input bit b, output int n);
		int t [2] = '{0, 0};
		int k = 0;
		for (int i = 0; i < 20000 && k < 2; i++) begin
			@(posedge i_clk);
			if ((b ? btk[c] : t16[c]) === 1'b1) begin
				t[k] = i;
				k++;
			end
		end
		n = t[1] - t[0];
	endtask
	initial begin
		repeat (60000) @(posedge i_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		logic [7:0] d;
		logic [15:0] dv [3];
		logic [2:0] s;
		int n;
		repeat (4) @(posedge i_clk);
		chk("tx rest", txs, 2'h3);
		i_arst_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			stir();
			d = seed[31:24];
			host_u.acc(1'b1, 3'h6, 3'h7, seed[7:0], q);
			host_u.acc(1'b1, 3'h5, 3'h7, seed[15:8], q);
			host_u.acc(1'b1, 3'h7, 3'h7, d, q);
			host_u.acc(1'b0, 3'h6, 3'h7, 8'h00, q);
			chk("scratch a", q, seed[7:0]);
			host_u.acc(1'b0, 3'h5, 3'h7, 8'h00, q);
			chk("scratch b", q, seed[15:8]);
			host_u.acc(1'b1, 3'h6, 3'h0, d, q);
			chk("holding a", txh[0], d);
			host_u.acc(1'b0, 3'h5, 3'h0, 8'h00, q);
			chk("receive b", q, rxh[1]);
			chk("read oe", roe, 1'b1);
			host_u.acc(1'b1, 3'h6, 3'h1, d, q);
			chk("int enable a", ienb[0], d);
			host_u.acc(1'b1, 3'h5, 3'h4, seed[23:16], q);
			chk("modem ctl b", mctl[1], seed[23:16]);
			host_u.acc(1'b0, 3'h6, 3'h1, 8'h00, q);
			chk("int status a", q, ist[0]);
			host_u.acc(1'b0, 3'h5, 3'h5, 8'h00, q);
			chk("line status b", q, lst[1]);
			repeat (2) @(posedge i_clk);
			chk("tx line", txs, 2'(~txa | txb));
		end
		dv = '{16'h0001, 16'h0100, 16'h0002 + seed[2:0]};
		for (int i = 0; i < 3; i++) begin
			s = i[0] ? 3'h5 : 3'h6;
			host_u.acc(1'b1, s, 3'h3, 8'h80, q);
			host_u.acc(1'b1, s, 3'h0, dv[i][7:0], q);
			host_u.acc(1'b1, s, 3'h1, dv[i][15:8], q);
			host_u.acc(1'b0, s, 3'h1, 8'h00, q);
			chk("divisor high", q, dv[i][15:8]);
			gap(i % 2, 1'b0, n);
			chk("tick gap", n, dv[i]);
			gap(i % 2, 1'b1, n);
			chk("bit gap", n, 16 * dv[i]);
			host_u.acc(1'b1, s, 3'h3, 8'h00, q);
			host_u.acc(1'b0, s, 3'h0, 8'h00, q);
			chk("holding read", q, rxh[i % 2]);
		end
		for (int k = 0; k < 8; k++) begin
			stir();
			d = seed[7:0];
			pin <= k[0];
			host_u.acc(1'b1, 3'h3, 3'h1, k[2] ? 8'haa : 8'h55, q);
			host_u.acc(1'b1, 3'h3, 3'h6, {2'h0, k[1], 5'h00}, q);
			chk("control", pctl, {2'h0, k[1], 5'h00});
			host_u.acc(1'b1, 3'h3, 3'h4, d, q);
			chk("port out", pout, d);
			chk("port oe", poe, oe_exp(k[0], k[1], k[2]));
			host_u.acc(1'b0, 3'h3, 3'h0, 8'h00, q);
			chk("port in", q, oe_exp(k[0], k[1], k[2]) ? d : pins);
			host_u.acc(1'b0, 3'h3, 3'h5, 8'h00, q);
			chk("status", q, pstat);
			host_u.acc(1'b0, 3'h3, 3'h2, 8'h00, q);
			chk("command", q, pcmd);
		end
		wrap_up();
	end
endmodule
